/* design/ssm_pkg.sv */
// Shared constants for the synchronous serial master transmitter
package ssm_pkg;
    localparam int DATA_W        = 8;
    localparam int RELOAD_W      = 8;
    localparam int BIT_CNT_W     = 4;
    localparam logic [3:0] LAST_DATA_BIT = 4'h8;
    localparam logic [3:0] ACK_BIT       = 4'h9;
    // SPI rate select codes
    localparam logic [2:0] RATE_DIV4   = 3'h0;
    localparam logic [2:0] RATE_DIV16  = 3'h1;
    localparam logic [2:0] RATE_DIV64  = 3'h2;
    localparam logic [2:0] RATE_TIMER  = 3'h3;
    localparam logic [2:0] RATE_RELOAD = 3'h4;
    // Half-period counts in system clocks for fixed SPI rates
    localparam logic [7:0] HALF_DIV4  = 8'h02;
    localparam logic [7:0] HALF_DIV16 = 8'h08;
    localparam logic [7:0] HALF_DIV64 = 8'h20;
    localparam logic [7:0] RESET_RELOAD = 8'h04;
    typedef enum logic [3:0] {
        ST_IDLE, ST_SPI, ST_RS_SCL_LOW, ST_RS_SDA_HIGH, ST_RS_SCL_HIGH, ST_RS_SDA_LOW,
        ST_ST_SETUP, ST_ST_SDA_LOW, ST_TX_LOW, ST_TX_HIGH, ST_TX_WAIT_HIGH, ST_TX_HOLD
    } ssm_state_t;
endpackage

/* design/ssm_master.sv */
// Master shifting engine: SPI master and two-wire master transmit with start/restart
// Function
// - SPI master starts a byte exchange as soon as the buffer is written.
// - SPI input keeps shifting even with output disabled; bytes load the buffer.
// - SPI bit rate: clock/4, /16, /64, timer/2, or clock/(4*(reload+1)).
// - SPI bytes leave most significant bit first.
// - Clock idle level follows polarity; edge select pre-drives data; sample phase selectable.
// - Restart only taken when the master is idle; otherwise ignored.
// - Restart drives clock low, then releases data high for one generator period.
// - Data high at timeout releases clock; both high for one generator period.
// - Data low one period with clock high, clock low, request clears itself.
// - Start-seen sets on detection; event flag waits for generator timeout.
// - Collision if data low at clock rise or clock low before data driven low.
// - Two-wire buffer write sends one byte, sets buffer-full, starts generator.
// - Bits change after clock fall; clock low one period then high one period.
// - At eighth clock fall buffer-full clears and data line is released.
// - Ninth clock samples acknowledge: zero when acknowledged, one otherwise.
// - After ninth clock event flag sets; generator stops, clock held low.
// - Address byte: seven address bits then read/write bit, then acknowledge.
// - Buffer write while shifting sets write-collision and is discarded.
// - Start request makes a Start and sets event flag on completion.
// - Stop or restart request raises the event once the condition completes.
`timescale 1ns/1ps
module ssm_master
    import ssm_pkg::*;
(
    input  wire logic                       sys_clk,
    input  wire logic                       rst_n,
    input  wire logic                       two_wire_mode,
    input  wire logic [ssm_pkg::DATA_W-1:0] wr_data,
    input  wire logic                       wr_strobe,
    output logic      [ssm_pkg::DATA_W-1:0] transfer_buffer,
    input  wire logic [2:0]                 rate_select,
    input  wire logic [ssm_pkg::RELOAD_W-1:0] rate_reload_value,
    input  wire logic                       timer_tick,
    input  wire logic                       clock_polarity_select,
    input  wire logic                       clock_edge_select,
    input  wire logic                       sample_phase_select,
    input  wire logic                       start_request_set,
    input  wire logic                       restart_request_set,
    input  wire logic                       stop_request_set,
    output logic                            start_request,
    output logic                            restart_request,
    output logic                            stop_request,
    input  wire logic                       port_event_clear,
    output logic                            port_event_flag,
    output logic                            buffer_full_flag,
    input  wire logic                       write_collision_clear,
    output logic                            write_collision_flag,
    output logic                            ack_status,
    output logic                            start_seen,
    output logic                            bus_collision_flag,
    input  wire logic                       bus_collision_clear,
    output logic                            spi_sck,
    output logic                            spi_sdo,
    input  wire logic                       spi_sdi,
    input  wire logic                       scl_in,
    output logic                            scl_out,
    output logic                            scl_oe,
    input  wire logic                       sda_in,
    output logic                            sda_out,
    output logic                            sda_oe
);
    import ssm_pkg::*;

    ssm_state_t                state_r;
    logic [DATA_W-1:0]         shift_r;
    logic [DATA_W-1:0]         rx_r;
    logic [BIT_CNT_W-1:0]      bit_cnt_r;
    logic [RELOAD_W+1:0]       brg_r;
    logic                      phase_r;
    logic                      scl_low_r;
    logic                      sda_low_r;
    logic                      sck_r;
    logic                      sdo_r;
    logic                      scl_d_r;
    logic                      sda_d_r;
    logic                      set_event;
    logic                      set_write_collision_flag;
    logic                      set_bcol;
    logic                      load_buf;
    logic                      brg_done;
    logic                      busy;
    logic [RELOAD_W+1:0]       half_cnt;
    logic [RELOAD_W+1:0]       i2c_cnt;
    logic                      spi_tick;

    assign busy     = (state_r != ST_IDLE);
    assign brg_done = (brg_r == '0);
    // I2C generator period in system clocks: reload+1 (shared reload value)
    assign i2c_cnt  = {2'b00, rate_reload_value};

    always_comb begin
        case (rate_select)
            RATE_DIV4:   half_cnt = {2'b00, HALF_DIV4} - 1'b1;
            RATE_DIV16:  half_cnt = {2'b00, HALF_DIV16} - 1'b1;
            RATE_DIV64:  half_cnt = {2'b00, HALF_DIV64} - 1'b1;
            // Half bit is 2*(reload+1) clocks, so a full bit is 4*(reload+1)
            RATE_RELOAD: half_cnt = {1'b0, rate_reload_value, 1'b0} + 10'h001;
            default:     half_cnt = '0;
        endcase
    end

    // Timer mode: each timer tick is one half bit, giving timer/2 per bit
    assign spi_tick = (rate_select == RATE_TIMER) ? timer_tick : brg_done;

    // Bus line sampling for edge detection
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end else begin
            scl_d_r <= scl_in;
            sda_d_r <= sda_in;
        end
    end

    // Start-seen: data falls while clock high
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            start_seen <= 1'b0;
        end else if (two_wire_mode && scl_in && scl_d_r && sda_d_r && !sda_in) begin
            start_seen <= 1'b1;
        end else if (two_wire_mode && scl_in && !sda_d_r && sda_in) begin
            start_seen <= 1'b0;
        end
    end

    // Main sequencer
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r   <= ST_IDLE;
            shift_r   <= '0;
            rx_r      <= '0;
            bit_cnt_r <= '0;
            brg_r     <= '0;
            phase_r   <= 1'b0;
            scl_low_r <= 1'b0;
            sda_low_r <= 1'b0;
            sck_r     <= 1'b0;
            sdo_r     <= 1'b0;
            ack_status <= 1'b0;
            set_event <= 1'b0;
            set_bcol  <= 1'b0;
            load_buf  <= 1'b0;
        end else begin
            set_event <= 1'b0;
            set_bcol  <= 1'b0;
            load_buf  <= 1'b0;
            if (!brg_done) begin
                brg_r <= brg_r - 1'b1;
            end
            case (state_r)
                ST_IDLE: begin
                    sck_r <= clock_polarity_select;
                    if (wr_strobe && !two_wire_mode) begin
                        shift_r   <= wr_data;
                        sdo_r     <= wr_data[DATA_W-1];
                        bit_cnt_r <= '0;
                        phase_r   <= 1'b0;
                        brg_r     <= half_cnt;
                        state_r   <= ST_SPI;
                    end else if (two_wire_mode && wr_strobe) begin
                        shift_r   <= wr_data;
                        sda_low_r <= ~wr_data[DATA_W-1];
                        bit_cnt_r <= '0;
                        scl_low_r <= 1'b1;
                        brg_r     <= i2c_cnt;
                        state_r   <= ST_TX_LOW;
                    end else if (two_wire_mode && restart_request) begin
                        scl_low_r <= 1'b1;
                        state_r   <= ST_RS_SCL_LOW;
                    end else if (two_wire_mode && start_request) begin
                        scl_low_r <= 1'b0;
                        sda_low_r <= 1'b0;
                        brg_r     <= i2c_cnt;
                        state_r   <= ST_ST_SETUP;
                    end else if (two_wire_mode && stop_request) begin
                        scl_low_r <= 1'b1;
                        sda_low_r <= 1'b1;
                        brg_r     <= i2c_cnt;
                        state_r   <= ST_ST_SDA_LOW;
                    end
                end
                ST_SPI: begin
                    if (spi_tick) begin
                        brg_r   <= half_cnt;
                        phase_r <= ~phase_r;
                        sck_r   <= ~sck_r;
                        if (!phase_r) begin
                            // Leading edge: sample when sample phase clear, drive when edge select clear
                            if (!clock_edge_select && bit_cnt_r != '0) begin
                                sdo_r <= shift_r[DATA_W-1];
                            end
                            if (!sample_phase_select) begin
                                rx_r <= {rx_r[DATA_W-2:0], spi_sdi};
                            end
                        end else begin
                            if (sample_phase_select) begin
                                rx_r <= {rx_r[DATA_W-2:0], spi_sdi};
                            end
                            shift_r   <= {shift_r[DATA_W-2:0], 1'b0};
                            if (clock_edge_select) begin
                                sdo_r <= shift_r[DATA_W-2];
                            end
                            bit_cnt_r <= bit_cnt_r + 1'b1;
                            if (bit_cnt_r == LAST_DATA_BIT - 1'b1) begin
                                load_buf  <= 1'b1;
                                set_event <= 1'b1;
                                state_r   <= ST_IDLE;
                            end
                        end
                    end
                end
                ST_RS_SCL_LOW: begin
                    if (!scl_in) begin
                        brg_r     <= i2c_cnt;
                        sda_low_r <= 1'b0;
                        state_r   <= ST_RS_SDA_HIGH;
                    end
                end
                ST_RS_SDA_HIGH: begin
                    if (brg_done && sda_in) begin
                        scl_low_r <= 1'b0;
                        state_r   <= ST_RS_SCL_HIGH;
                        phase_r   <= 1'b0;
                    end
                end
                ST_RS_SCL_HIGH: begin
                    if (scl_in && !scl_d_r && !sda_in) begin
                        set_bcol <= 1'b1;
                        state_r  <= ST_IDLE;
                    end else if (phase_r && !scl_in) begin
                        set_bcol <= 1'b1;
                        state_r  <= ST_IDLE;
                    end else if (scl_in && !phase_r) begin
                        brg_r   <= i2c_cnt;
                        phase_r <= 1'b1;
                    end else if (phase_r && brg_done) begin
                        sda_low_r <= 1'b1;
                        brg_r     <= i2c_cnt;
                        state_r   <= ST_RS_SDA_LOW;
                    end
                end
                ST_RS_SDA_LOW: begin
                    if (brg_done) begin
                        scl_low_r <= 1'b1;
                        set_event <= 1'b1;
                        state_r   <= ST_IDLE;
                    end
                end
                ST_ST_SETUP: begin
                    if (brg_done) begin
                        sda_low_r <= 1'b1;
                        brg_r     <= i2c_cnt;
                        state_r   <= ST_RS_SDA_LOW;
                    end
                end
                ST_ST_SDA_LOW: begin
                    // Stop: clock released, then data released after one period each
                    if (brg_done && scl_low_r) begin
                        scl_low_r <= 1'b0;
                        brg_r     <= i2c_cnt;
                    end else if (brg_done && sda_low_r) begin
                        sda_low_r <= 1'b0;
                        set_event <= 1'b1;
                        state_r   <= ST_IDLE;
                    end
                end
                ST_TX_LOW: begin
                    if (brg_done) begin
                        scl_low_r <= 1'b0;
                        state_r   <= ST_TX_WAIT_HIGH;
                    end
                end
                ST_TX_WAIT_HIGH: begin
                    if (scl_in) begin
                        brg_r   <= i2c_cnt;
                        state_r <= ST_TX_HIGH;
                        if (bit_cnt_r == LAST_DATA_BIT) begin
                            ack_status <= sda_in;
                        end
                    end
                end
                ST_TX_HIGH: begin
                    if (brg_done) begin
                        scl_low_r <= 1'b1;
                        shift_r   <= {shift_r[DATA_W-2:0], 1'b0};
                        bit_cnt_r <= bit_cnt_r + 1'b1;
                        brg_r     <= i2c_cnt;
                        if (bit_cnt_r == LAST_DATA_BIT) begin
                            set_event <= 1'b1;
                            brg_r     <= '0;
                            state_r   <= ST_IDLE;
                        end else begin
                            state_r <= ST_TX_LOW;
                            // Next bit changes just after the clock falls, never while high
                            if (bit_cnt_r == LAST_DATA_BIT - 1'b1) begin
                                sda_low_r <= 1'b0;
                            end else begin
                                sda_low_r <= ~shift_r[DATA_W-2];
                            end
                        end
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    // Buffer write with collision protection
    assign set_write_collision_flag = wr_strobe && busy;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            transfer_buffer <= '0;
        end else if (load_buf) begin
            transfer_buffer <= rx_r;
        end else if (wr_strobe && !busy) begin
            transfer_buffer <= wr_data;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            buffer_full_flag <= 1'b0;
        end else if (wr_strobe && !busy) begin
            buffer_full_flag <= 1'b1;
        end else if (state_r == ST_TX_HIGH && brg_done && bit_cnt_r == LAST_DATA_BIT - 1'b1) begin
            buffer_full_flag <= 1'b0;
        end else if (load_buf) begin
            buffer_full_flag <= 1'b1;
        end
    end

    // Sticky flags: a set in the same cycle as a clear wins
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            write_collision_flag <= 1'b0;
        end else if (set_write_collision_flag) begin
            write_collision_flag <= 1'b1;
        end else if (write_collision_clear) begin
            write_collision_flag <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            port_event_flag <= 1'b0;
        end else if (set_event) begin
            port_event_flag <= 1'b1;
        end else if (port_event_clear) begin
            port_event_flag <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            bus_collision_flag <= 1'b0;
        end else if (set_bcol) begin
            bus_collision_flag <= 1'b1;
        end else if (bus_collision_clear) begin
            bus_collision_flag <= 1'b0;
        end
    end

    // Condition requests; ignored unless idle, cleared on acceptance completion
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            start_request   <= 1'b0;
            restart_request <= 1'b0;
            stop_request    <= 1'b0;
        end else begin
            if (restart_request_set && !busy && two_wire_mode) begin
                restart_request <= 1'b1;
            end else if (state_r == ST_RS_SDA_LOW && brg_done) begin
                restart_request <= 1'b0;
            end
            if (start_request_set && !busy && two_wire_mode) begin
                start_request <= 1'b1;
            end else if (state_r == ST_RS_SDA_LOW && brg_done) begin
                start_request <= 1'b0;
            end
            if (stop_request_set && !busy && two_wire_mode) begin
                stop_request <= 1'b1;
            end else if (state_r == ST_ST_SDA_LOW && brg_done && !scl_low_r) begin
                stop_request <= 1'b0;
            end
        end
    end

    assign spi_sck = sck_r;
    assign spi_sdo = sdo_r;
    assign scl_out = 1'b0;
    assign sda_out = 1'b0;
    assign scl_oe  = two_wire_mode & scl_low_r;
    assign sda_oe  = two_wire_mode & sda_low_r;
endmodule

/* testbench/ssm_master_asserts.sv */
// Checker on the serial master ports, bound below
`timescale 1ns/1ps
module ssm_master_asserts
    import ssm_pkg::*;
(
    input wire logic              sys_clk,
    input wire logic              rst_n,
    input wire logic              two_wire_mode,
    input wire logic              wr_strobe,
    input wire logic [DATA_W-1:0] transfer_buffer,
    input wire logic [2:0]        rate_select,
    input wire logic              buffer_full_flag,
    input wire logic              write_collision_flag,
    input wire logic              restart_request_set,
    input wire logic              restart_request,
    input wire logic              start_seen,
    input wire logic              scl_oe,
    input wire logic              sda_oe,
    input wire logic              spi_sck
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    property p_take;
        two_wire_mode && wr_strobe && !buffer_full_flag && !write_collision_flag
        |=> buffer_full_flag ^ write_collision_flag;
    endproperty
    a_take: assert property (p_take) else $error("write neither taken nor refused");
    property p_write_collision_flag;
        two_wire_mode && wr_strobe && buffer_full_flag
        |=> write_collision_flag && $stable(transfer_buffer);
    endproperty
    a_write_collision_flag: assert property (p_write_collision_flag) else $error("write during shift not refused");
    property p_shift;
        two_wire_mode && (buffer_full_flag || $past(buffer_full_flag)) && $changed(sda_oe)
        |-> scl_oe;
    endproperty
    a_shift: assert property (p_shift) else $error("data moved with clock high");
    property p_bf;
        two_wire_mode && $fell(buffer_full_flag) |-> !sda_oe && scl_oe;
    endproperty
    a_bf: assert property (p_bf) else $error("data not released at eighth fall");
    property p_rs_busy;
        restart_request_set && buffer_full_flag |=> !restart_request;
    endproperty
    a_rs_busy: assert property (p_rs_busy) else $error("restart taken while busy");
    property p_rs_go;
        $rose(restart_request) |-> ##[0:3] (scl_oe && !sda_oe);
    endproperty
    a_rs_go: assert property (p_rs_go) else $error("restart did not open");
    property p_rs_end;
        $fell(restart_request) |-> scl_oe && sda_oe && start_seen;
    endproperty
    a_rs_end: assert property (p_rs_end) else $error("restart ended wrongly");
    property p_div4;
        !two_wire_mode && rate_select == RATE_DIV4 && $changed(spi_sck) |=> $stable(spi_sck);
    endproperty
    a_div4: assert property (p_div4) else $error("fastest clock half period wrong");
endmodule
bind ssm_master ssm_master_asserts u_chk (.*);

/* testbench/ssm_slave_model.sv */
// Behavioural far-side slave for both serial modes
`timescale 1ns/1ps
module ssm_slave_model (
    input  wire logic       sys_clk,
    input  wire logic       scl,
    input  wire logic       sda,
    input  wire logic       ack_en,
    input  wire logic       spi_sck,
    input  wire logic       spi_sdo,
    input  wire logic       cpol,
    input  wire logic [7:0] spi_reply,
    output logic            sda_pull,
    output logic            spi_sdi,
    output logic [7:0]      i2c_rx,
    output logic [7:0]      spi_rx
);
    logic [3:0] n = 4'h0;
    logic [2:0] m = 3'h0;
    logic       scl_d = 1'b1;
    logic       sda_d = 1'b1;
    logic       sck_d = 1'b0;
    initial sda_pull = 1'b0;
    // Reply moves on after each sampling edge, most significant bit first
    assign spi_sdi = spi_reply[3'h7 - m];
    always @(posedge sys_clk) begin
        scl_d <= scl;
        sda_d <= sda;
        sck_d <= spi_sck;
        if (spi_sck != sck_d && spi_sck != cpol) begin
            spi_rx <= {spi_rx[6:0], spi_sdo};
            m <= m + 3'h1;
        end
        if (scl && scl_d && sda_d && !sda) begin
            n <= 4'h0;
        end else if (scl && !scl_d) begin
            if (n < 4'h8) i2c_rx <= {i2c_rx[6:0], sda};
            n <= n + 4'h1;
        end else if (!scl && scl_d) begin
            sda_pull <= (n == 4'h8) && ack_en;
            if (n == 4'h9) n <= 4'h0;
        end
    end
endmodule

/* testbench/ssm_master_tb_top.sv */
// Self-checking bench for the serial master
`timescale 1ns/1ps
module ssm_master_tb_top;
    import ssm_pkg::*;
    typedef struct {int k; logic [7:0] a; logic [7:0] b;} ssm_note_t;
    logic sys_clk = 1'b0, rst_n = 1'b0, two_wire_mode = 1'b0, timer_tick = 1'b0;
    logic [7:0] wr_data = 8'h00, rate_reload_value = 8'h01, reply = 8'h00;
    logic [2:0] rate_select = 3'h0;
    logic clock_polarity_select = 1'b0, clock_edge_select = 1'b1, sample_phase_select = 1'b0;
    logic [5:0] pls = 6'h00;
    logic wr_strobe, start_request_set, restart_request_set, stop_request_set;
    logic port_event_clear, write_collision_clear, bus_collision_clear = 1'b0;
    logic start_request, restart_request, stop_request, port_event_flag, buffer_full_flag;
    logic write_collision_flag, ack_status, start_seen, bus_collision_flag;
    logic spi_sck, spi_sdo, spi_sdi, scl_in, scl_out, scl_oe, sda_in, sda_out, sda_oe;
    logic ack_en = 1'b1, sda_pull, ev_d = 1'b0;
    logic [7:0] transfer_buffer, i2c_rx, spi_rx, d;
    ssm_note_t notes[$];
    ssm_note_t nt;
    int seed = 32'h23976f7e, cyc = 0, bad_count = 0, cmp_count = 0;
    assign {write_collision_clear, port_event_clear, stop_request_set, restart_request_set,
            start_request_set, wr_strobe} = pls;
    // Both lines have pull-ups
    assign scl_in = !scl_oe;
    assign sda_in = !(sda_oe || sda_pull);
    always #20 sys_clk = ~sys_clk;
    ssm_master DUT (.*);
    ssm_slave_model u_slave (.sys_clk(sys_clk), .scl(scl_in), .sda(sda_in), .ack_en(ack_en),
        .spi_sck(spi_sck), .spi_sdo(spi_sdo), .cpol(clock_polarity_select), .spi_reply(reply),
        .sda_pull(sda_pull), .spi_sdi(spi_sdi), .i2c_rx(i2c_rx), .spi_rx(spi_rx));
    task automatic wrap_up();
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        chk8({7'h00, got}, {7'h00, exp});
    endtask
    task automatic fire(input int k);
        @(posedge sys_clk);
        #1 pls[k] = 1'b1;
        @(posedge sys_clk);
        #1 pls[k] = 1'b0;
    endtask
    task automatic wait_evt();
        int i;
        for (i = 0; i < 4000 && port_event_flag !== 1'b1; i++) @(posedge sys_clk);
        if (i == 4000) bad_count++;
        fire(4);
    endtask
    always @(posedge sys_clk) begin
        #1;
        cyc++;
        timer_tick = (cyc % 4 == 0);
        if (cyc > 20000) begin
            bad_count++;
            wrap_up();
        end
    end
    always @(negedge sys_clk) begin
        ev_d <= port_event_flag;
        if (port_event_flag === 1'b1 && ev_d !== 1'b1) begin
            if (notes.size() == 0) begin
                chk1(1'b1, 1'b0);
            end else begin
                nt = notes.pop_front();
                if (nt.k == 0) begin
                    chk8(transfer_buffer, nt.a);
                    chk8(spi_rx, nt.b);
                end else if (nt.k == 1) begin
                    chk1(ack_status, nt.a[0]);
                    chk8(i2c_rx, nt.b);
                end else if (nt.k == 2) begin
                    chk1(start_seen, nt.a[0]);
                    chk1(bus_collision_flag, 1'b0);
                end else begin
                    chk1(stop_request, 1'b0);
                end
            end
        end
    end
    initial begin
        repeat (5) @(posedge sys_clk);
        #1 rst_n = 1'b1;
        two_wire_mode = 1'b1;
        rate_reload_value = 8'h02;
        repeat (3) @(posedge sys_clk);
        notes.push_back('{2, 8'h01, 8'h00});
        fire(1);
        wait_evt();
        for (int b = 0; b < 3; b++) begin
            d = 8'($random(seed));
            ack_en = (b != 1);
            notes.push_back('{1, {7'h00, b == 1}, d});
            wr_data = d;
            fire(0);
            if (b == 0) begin
                repeat (6) @(posedge sys_clk);
                #1 wr_data = ~d;
                fire(0);
                chk1(write_collision_flag, 1'b1);
                chk8(transfer_buffer, d);
                fire(2);
                chk1(restart_request, 1'b0);
                fire(5);
            end
            wait_evt();
            $display("two-wire byte %0d done", b);
        end
        notes.push_back('{2, 8'h01, 8'h00});
        fire(2);
        wait_evt();
        notes.push_back('{3, 8'h00, 8'h00});
        fire(3);
        wait_evt();
        $display("bus conditions done");
        // SPI runs last so its received-byte full flag cannot leak into two-wire writes
        two_wire_mode = 1'b0;
        for (int r = 0; r < 5; r++) begin
            rate_select = 3'(r);
            clock_polarity_select = r[0];
            clock_edge_select = r[1];
            reply = 8'($random(seed));
            d = 8'($random(seed));
            notes.push_back('{0, reply, d});
            repeat (3) @(posedge sys_clk);
            #1 wr_data = d;
            fire(0);
            wait_evt();
            $display("spi rate code %0d done", r);
        end
        if (notes.size() != 0) bad_count++;
        wrap_up();
    end
endmodule
